// [hdl/wkt_defines.svh]
// Function
// - Radio interrupt rising edge captures timer and sub-tick when the enable bit and radio capture are both set.
// - Compare select 11 interrupts and clears timer, 10 interrupts and wraps, 0x off.
// - Match when timer equals high compare byte above low compare byte.
// - Compare interrupt lasts between half and one full 32 kHz period.
// - Wake request precedes the compare interrupt.
// - Enable bit runs the timer; cleared, timer holds and outputs are low.
// - Compare bytes at 0xb4 and 0xb5, read/write, reset 0xff.
// - Capture timer bytes at 0xb6 and 0xab, read-only, reset 0x00.
// - Fine capture at 0xac holds MCU cycles since last rising tick edge, saturating at 511, LSB dropped.
// - Captured values may be off by up to 250 ns.
// - Writing one to bit 4 triggers a software capture when the enable bit is already set.
`ifndef WKT_DEFINES_SVH
`define WKT_DEFINES_SVH

`define WKT_ADDR_CONFIG 8'hb3
`define WKT_ADDR_CMP_LO 8'hb4
`define WKT_ADDR_CMP_HI 8'hb5
`define WKT_ADDR_CPT_LO 8'hb6
`define WKT_ADDR_CPT_HI 8'hab
`define WKT_ADDR_CPT_SUB 8'hac

`define WKT_BIT_ON 0
`define WKT_BIT_SEL_LO 1
`define WKT_BIT_SEL_HI 2
`define WKT_BIT_RADIO 3
`define WKT_BIT_SOFT 4

`define WKT_RST_CMP 8'hff
`define WKT_RST_CPT 8'h00
`define WKT_RST_CFG 4'h0

`define WKT_SEL_CLEAR 2'h3
`define WKT_SEL_WRAP 2'h2

`define WKT_SUB_W 9
`define WKT_CLK_NS 25
`define WKT_T32K_NS 30520
`define WKT_T32K_CYC (`WKT_T32K_NS / `WKT_CLK_NS)
`define WKT_HALF_CYC (`WKT_T32K_CYC / 2)
`define WKT_TOL_NS 250
`define WKT_TOL_CYC (`WKT_TOL_NS / `WKT_CLK_NS)

`endif

// [hdl/wkt_pkg.sv]
package wkt_pkg;

    typedef struct packed {
        logic [15:0] timer;
        logic [7:0] cmp_lo;
        logic [7:0] cmp_hi;
        logic [7:0] cpt_lo;
        logic [7:0] cpt_hi;
        logic [7:0] cpt_sub;
        logic on;
        logic [1:0] sel;
        logic radio_en;
        logic [8:0] sub;
        logic irq;
        logic wake;
        logic [7:0] rdata;
    } wkt_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } wkt_sfr_req_t;

endpackage : wkt_pkg

// [hdl/wkt_edge.sv]
`timescale 1ns/100ps
module wkt_edge (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic level,
    output logic rise,
    output logic fall
);
    logic prev;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev <= 1'b0;
        end else begin
            prev <= level;
        end
    end

    assign rise = level & ~prev;
    assign fall = ~level & prev;
endmodule : wkt_edge

// [hdl/wkt_top.sv]
`timescale 1ns/100ps
`include "wkt_defines.svh"
module wkt_top
    import wkt_pkg::*;
#(
    parameter logic [15:0] PRE_COMPARE_MARGIN = 16'h0002
) (
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic CLK32K_IN,
    input wire logic RADIO_IRQ,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_WE,
    input wire logic SFR_RE,
    output logic [7:0] SFR_RDATA,
    output logic WAKE_IRQ,
    output logic WAKE_REQ
);
    wkt_state_t s;
    wkt_state_t next_s;
    wkt_sfr_req_t req;
    logic tick_rise;
    logic tick_fall;
    logic radio_rise;
    logic match;
    logic soft_cap;
    logic do_cap;
    logic [15:0] cmp;

    if (PRE_COMPARE_MARGIN == 16'h0000) begin : g_bad_margin
        $error("PRE_COMPARE_MARGIN must be at least one tick");
    end

    assign req = '{addr: SFR_ADDR, wdata: SFR_WDATA, we: SFR_WE, re: SFR_RE};

    wkt_edge u_tick_edge (
        .clk(CLK_SYS),
        .rst_b(RST_B),
        .level(CLK32K_IN),
        .rise(tick_rise),
        .fall(tick_fall)
    );

    wkt_edge u_radio_edge (
        .clk(CLK_SYS),
        .rst_b(RST_B),
        .level(RADIO_IRQ),
        .rise(radio_rise),
        .fall()
    );

    assign cmp = {s.cmp_hi, s.cmp_lo};
    assign match = (s.timer == cmp);
    assign soft_cap = req.we && (req.addr == `WKT_ADDR_CONFIG) && req.wdata[`WKT_BIT_SOFT];
    assign do_cap = s.on && (soft_cap || (s.radio_en && radio_rise));

    always_comb begin
        next_s = s;
        // Register reads, answered one cycle later
        if (req.re) begin
            unique case (req.addr)
                `WKT_ADDR_CONFIG: next_s.rdata = {4'h0, s.radio_en, s.sel, s.on};
                `WKT_ADDR_CMP_LO: next_s.rdata = s.cmp_lo;
                `WKT_ADDR_CMP_HI: next_s.rdata = s.cmp_hi;
                `WKT_ADDR_CPT_LO: next_s.rdata = s.cpt_lo;
                `WKT_ADDR_CPT_HI: next_s.rdata = s.cpt_hi;
                `WKT_ADDR_CPT_SUB: next_s.rdata = s.cpt_sub;
                default: next_s.rdata = 8'h00;
            endcase
        end
        // Register writes; capture bytes ignore writes
        if (req.we) begin
            unique case (req.addr)
                `WKT_ADDR_CONFIG: begin
                    next_s.on = req.wdata[`WKT_BIT_ON];
                    next_s.sel = req.wdata[`WKT_BIT_SEL_HI:`WKT_BIT_SEL_LO];
                    next_s.radio_en = req.wdata[`WKT_BIT_RADIO];
                end
                `WKT_ADDR_CMP_LO: next_s.cmp_lo = req.wdata;
                `WKT_ADDR_CMP_HI: next_s.cmp_hi = req.wdata;
                default: begin
                end
            endcase
        end
        // Sub-tick counter, saturating
        if (tick_rise) begin
            next_s.sub = '0;
        end else if (!(&s.sub)) begin
            next_s.sub = s.sub + 9'h001;
        end
        // Capture of coarse and fine time
        if (do_cap) begin
            next_s.cpt_lo = s.timer[7:0];
            next_s.cpt_hi = s.timer[15:8];
            next_s.cpt_sub = s.sub[8:1];
        end
        // Early wake request ahead of the match
        if (s.sel[1] && !s.irq && (s.timer == cmp - PRE_COMPARE_MARGIN)) begin
            next_s.wake = 1'b1;
        end
        if (!s.sel[1]) begin
            next_s.wake = 1'b0;
        end
        // Timer and compare interrupt
        if (s.on && tick_rise) begin
            if (s.sel == `WKT_SEL_CLEAR && match) begin
                next_s.timer = 16'h0000;
            end else begin
                next_s.timer = s.timer + 16'h0001;
            end
            if (s.sel[1] && match) begin
                next_s.irq = 1'b1;
                next_s.wake = 1'b0;
            end
        end else if (tick_fall) begin
            next_s.irq = 1'b0;
        end
        if (!s.on) begin
            next_s.irq = 1'b0;
            next_s.wake = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            s <= '{timer: 16'h0000, cmp_lo: `WKT_RST_CMP, cmp_hi: `WKT_RST_CMP,
                   cpt_lo: `WKT_RST_CPT, cpt_hi: `WKT_RST_CPT, cpt_sub: `WKT_RST_CPT,
                   on: 1'b0, sel: 2'h0, radio_en: 1'b0, sub: 9'h000,
                   irq: 1'b0, wake: 1'b0, rdata: 8'h00};
        end else begin
            s <= next_s;
        end
    end

    assign SFR_RDATA = s.rdata;
    assign WAKE_IRQ = s.irq;
    assign WAKE_REQ = s.wake;

    // Helper: length of the current interrupt pulse
    logic [11:0] irq_len;

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            irq_len <= 12'h000;
        end else if (s.irq) begin
            irq_len <= irq_len + 12'h001;
        end else begin
            irq_len <= 12'h000;
        end
    end

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_B);

    sequence radio_event_s;
        s.on && s.radio_en && radio_rise;
    endsequence

    sequence soft_event_s;
        s.on && soft_cap;
    endsequence

    sequence match_tick_s;
        s.on && tick_rise && s.sel[1] && match && !s.irq;
    endsequence

    radio_capture_a: assert property (
        radio_event_s |=> (s.cpt_lo == $past(s.timer[7:0])) && (s.cpt_hi == $past(s.timer[15:8]))
                          && (s.cpt_sub == $past(s.sub[8:1])))
        else $error("radio capture missed");

    soft_capture_a: assert property (
        soft_event_s |=> {s.cpt_hi, s.cpt_lo} == $past(s.timer))
        else $error("soft capture missed");

    compare_off_a: assert property (
        $rose(s.irq) |-> $past(s.sel[1]))
        else $error("interrupt raised with compare disabled");

    clear_mode_a: assert property (
        match_tick_s and (s.sel == `WKT_SEL_CLEAR) |=> s.irq && (s.timer == 16'h0000))
        else $error("clear mode did not reset timer");

    wrap_mode_a: assert property (
        match_tick_s and (s.sel == `WKT_SEL_WRAP)
        |=> s.irq && (s.timer == $past(s.timer) + 16'h0001))
        else $error("wrap mode timer step wrong");

    match_value_a: assert property (
        $rose(s.irq) |-> $past(s.timer) == $past(cmp))
        else $error("interrupt without match");

    irq_length_a: assert property (
        irq_len <= 12'(`WKT_T32K_CYC))
        else $error("interrupt held too long");

    wake_first_a: assert property (
        $rose(s.irq) |-> $past(s.wake))
        else $error("interrupt before wake request");

    off_quiet_a: assert property (
        !s.on |=> !WAKE_IRQ && !WAKE_REQ && $stable(s.timer))
        else $error("disabled timer not quiet");

    subtick_restart_a: assert property (
        tick_rise |=> s.sub == 9'h000 ##1 s.sub == 9'h001 || tick_rise)
        else $error("sub-tick did not restart");

    sequence cfg_write_s;
        req.we && (req.addr == `WKT_ADDR_CONFIG);
    endsequence

    sequence timer_step_s;
        s.on && tick_rise && !((s.sel == `WKT_SEL_CLEAR) && match);
    endsequence

    sequence irq_end_s;
        $fell(s.irq) && $past(s.on);
    endsequence

    sequence wake_point_s;
        s.on && s.sel[1] && !s.irq && (s.timer == cmp - PRE_COMPARE_MARGIN);
    endsequence

    cfg_write_a: assert property (
        cfg_write_s |=> (s.on == $past(req.wdata[`WKT_BIT_ON]))
                        && (s.sel == $past(req.wdata[`WKT_BIT_SEL_HI:`WKT_BIT_SEL_LO]))
                        && (s.radio_en == $past(req.wdata[`WKT_BIT_RADIO])))
        else $error("config write not taken");

    cmp_lo_write_a: assert property (
        req.we && (req.addr == `WKT_ADDR_CMP_LO) |=> s.cmp_lo == $past(req.wdata))
        else $error("compare low write lost");

    cmp_hi_write_a: assert property (
        req.we && (req.addr == `WKT_ADDR_CMP_HI) |=> s.cmp_hi == $past(req.wdata))
        else $error("compare high write lost");

    cmp_hold_a: assert property (
        !(req.we && ((req.addr == `WKT_ADDR_CMP_LO) || (req.addr == `WKT_ADDR_CMP_HI)))
        |=> $stable({s.cmp_hi, s.cmp_lo}))
        else $error("compare value changed without write");

    capture_readonly_a: assert property (
        !do_cap |=> $stable({s.cpt_hi, s.cpt_lo, s.cpt_sub}))
        else $error("capture bytes changed without capture");

    read_cmp_lo_a: assert property (
        req.re && (req.addr == `WKT_ADDR_CMP_LO) |=> SFR_RDATA == $past(s.cmp_lo))
        else $error("compare low read wrong");

    read_cmp_hi_a: assert property (
        req.re && (req.addr == `WKT_ADDR_CMP_HI) |=> SFR_RDATA == $past(s.cmp_hi))
        else $error("compare high read wrong");

    read_cpt_lo_a: assert property (
        req.re && (req.addr == `WKT_ADDR_CPT_LO) |=> SFR_RDATA == $past(s.cpt_lo))
        else $error("capture low read wrong");

    read_cpt_hi_a: assert property (
        req.re && (req.addr == `WKT_ADDR_CPT_HI) |=> SFR_RDATA == $past(s.cpt_hi))
        else $error("capture high read wrong");

    read_cpt_sub_a: assert property (
        req.re && (req.addr == `WKT_ADDR_CPT_SUB) |=> SFR_RDATA == $past(s.cpt_sub))
        else $error("fine capture read wrong");

    read_config_a: assert property (
        req.re && (req.addr == `WKT_ADDR_CONFIG) |=> SFR_RDATA[7:4] == 4'h0)
        else $error("config upper bits not zero");

    read_hold_a: assert property (
        !req.re |=> $stable(SFR_RDATA))
        else $error("read data changed without read");

    timer_step_a: assert property (
        timer_step_s |=> s.timer == $past(s.timer) + 16'h0001)
        else $error("timer did not step");

    timer_hold_a: assert property (
        !(s.on && tick_rise) |=> $stable(s.timer))
        else $error("timer moved without tick");

    wake_set_a: assert property (
        wake_point_s |=> s.wake)
        else $error("wake request not raised");

    wake_off_a: assert property (
        !s.sel[1] |=> !s.wake)
        else $error("wake request with compare off");

    wake_drop_a: assert property (
        $rose(s.irq) |-> !s.wake)
        else $error("wake request not dropped at interrupt");

    irq_min_a: assert property (
        irq_end_s |-> irq_len >= 12'(`WKT_HALF_CYC - `WKT_TOL_CYC))
        else $error("interrupt too short");

    irq_drop_a: assert property (
        s.irq && tick_fall |=> !s.irq)
        else $error("interrupt not ended at falling edge");

    irq_needs_on_a: assert property (
        $rose(s.irq) |-> $past(s.on))
        else $error("interrupt while disabled");

    sub_count_a: assert property (
        RST_B && !tick_rise && !(&s.sub) |=> s.sub == $past(s.sub) + 9'h001)
        else $error("sub-tick did not count");

    sub_hold_a: assert property (
        !tick_rise && (&s.sub) |=> &s.sub)
        else $error("sub-tick did not saturate");

    capture_fine_a: assert property (
        do_cap |=> s.cpt_sub == $past(s.sub[8:1]))
        else $error("fine capture wrong");

endmodule : wkt_top

// [test/wkt_mcu_model.sv]
`timescale 1ns/100ps
module wkt_mcu_model (
    input wire logic clk,
    output logic clk32k,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic we,
    output logic re,
    input wire logic [7:0] rdata
);
    int ph = 0;
    initial begin
        clk32k = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        we = 1'b0;
        re = 1'b0;
    end
    // Free running 32 kHz source
    always @(posedge clk) begin
        ph <= (ph == 609) ? 0 : ph + 1;
        if (ph == 609) clk32k <= ~clk32k;
    end
    // No interrupts here, pairs stay atomic
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
        addr <= ~a;
    endtask : wr
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        addr <= ~a;
        @(posedge clk);
        #1;
        d = rdata;
    endtask : rd
endmodule : wkt_mcu_model

// [test/wkt_top_tb.sv]
`timescale 1ns/100ps
module wkt_top_tb;
    logic clk_sys;
    logic rst_b;
    logic radio_irq;
    logic clk32k;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
    logic [7:0] rdata;
    logic wake_irq;
    logic wake_req;
    logic seen;
    logic [15:0] len;
    int fails = 0;
    int cmp_count = 0;
    wkt_top #(.PRE_COMPARE_MARGIN(16'h0002)) i_wkt_top (.CLK_SYS(clk_sys), .RST_B(rst_b),
        .CLK32K_IN(clk32k), .RADIO_IRQ(radio_irq), .SFR_ADDR(addr), .SFR_WDATA(wdata),
        .SFR_WE(we), .SFR_RE(re), .SFR_RDATA(rdata), .WAKE_IRQ(wake_irq), .WAKE_REQ(wake_req));
    wkt_mcu_model i_wkt_mcu_model (.clk(clk_sys), .clk32k(clk32k), .addr(addr),
        .wdata(wdata), .we(we), .re(re), .rdata(rdata));
    task bad(input string m);
        fails++;
        $display("BAD %0t %s", $time, m);
    endtask : bad
    task chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) bad($sformatf("got %h want %h", g, e));
    endtask : chk
    task chk_rng(input logic [15:0] g, input int lo, input int hi);
        cmp_count++;
        if ((g >= lo && g <= hi) !== 1'b1) bad($sformatf("%0d outside range", g));
    endtask : chk_rng
    task rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_wkt_mcu_model.rd(a, d);
        chk(d, e);
    endtask : rdc
    task tick(input int n);
        int k;
        logic p;
        repeat (n) begin
            k = 0;
            do begin
                p = clk32k;
                @(posedge clk_sys);
                #1;
                k++;
            end while (!(clk32k && !p) && k < 1300);
            if (k >= 1300) begin
                bad("no tick");
                finish_test();
            end
        end
    endtask : tick
    task wait_irq;
        int k;
        seen = 1'b0;
        len = 16'h0000;
        k = 0;
        while (wake_irq !== 1'b1 && k < 9000) begin
            if (wake_req === 1'b1) seen = 1'b1;
            @(posedge clk_sys);
            #1;
            k++;
        end
        if (k >= 9000) begin
            bad("no interrupt");
            finish_test();
        end
        chk({7'h00, wake_req}, 8'h00);
        chk({7'h00, seen}, 8'h01);
        while (wake_irq === 1'b1 && len < 16'h0800) begin
            @(posedge clk_sys);
            #1;
            len++;
        end
        chk_rng(len, 600, 1220);
    endtask : wait_irq
    task t_regs;
        rdc(8'hb4, 8'hff);
        rdc(8'hb5, 8'hff);
        rdc(8'hb6, 8'h00);
        rdc(8'hab, 8'h00);
        rdc(8'hac, 8'h00);
        rdc(8'h80, 8'h00);
        i_wkt_mcu_model.wr(8'hb6, 8'h5a);
        rdc(8'hb6, 8'h00);
        i_wkt_mcu_model.wr(8'hb4, 8'h05);
        i_wkt_mcu_model.wr(8'hb5, 8'h00);
        rdc(8'hb4, 8'h05);
        rdc(8'hb5, 8'h00);
        $display("regs done");
    endtask : t_regs
    task t_count;
        tick(1);
        i_wkt_mcu_model.wr(8'hb3, 8'h01);
        tick(3);
        i_wkt_mcu_model.wr(8'hb3, 8'h11);
        rdc(8'hb6, 8'h03);
        rdc(8'hab, 8'h00);
        rdc(8'hb3, 8'h01);
        i_wkt_mcu_model.wr(8'hb3, 8'h00);
        tick(2);
        chk({6'h00, wake_irq, wake_req}, 8'h00);
        i_wkt_mcu_model.wr(8'hb3, 8'h01);
        i_wkt_mcu_model.wr(8'hb3, 8'h11);
        rdc(8'hb6, 8'h03);
        $display("count done");
    endtask : t_count
    task t_clear;
        i_wkt_mcu_model.wr(8'hb3, 8'h07);
        wait_irq();
        i_wkt_mcu_model.wr(8'hb3, 8'h17);
        rdc(8'hb6, 8'h00);
        $display("clear done");
    endtask : t_clear
    task t_wrap;
        i_wkt_mcu_model.wr(8'hb3, 8'h05);
        wait_irq();
        i_wkt_mcu_model.wr(8'hb3, 8'h15);
        rdc(8'hb6, 8'h06);
        $display("wrap done");
    endtask : t_wrap
    task t_radio;
        logic [7:0] d;
        i_wkt_mcu_model.wr(8'hb3, 8'h09);
        tick(1);
        repeat (99) @(posedge clk_sys);
        radio_irq <= 1'b1;
        repeat (3) @(posedge clk_sys);
        radio_irq <= 1'b0;
        i_wkt_mcu_model.rd(8'hac, d);
        chk_rng({8'h00, d}, 44, 56);
        rdc(8'hb6, 8'h07);
        chk({7'h00, wake_irq}, 8'h00);
        i_wkt_mcu_model.wr(8'hb4, 8'h08);
        i_wkt_mcu_model.wr(8'hb3, 8'h03);
        radio_irq <= 1'b1;
        repeat (3) @(posedge clk_sys);
        radio_irq <= 1'b0;
        rdc(8'hb3, 8'h03);
        tick(2);
        @(posedge clk_sys);
        #1;
        chk({6'h00, wake_irq, wake_req}, 8'h00);
        rdc(8'hb6, 8'h07);
        $display("radio done");
    endtask : t_radio
    task finish_test;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        rst_b = 1'b0;
        radio_irq = 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_regs();
        t_count();
        t_clear();
        t_wrap();
        t_radio();
        finish_test();
    end
endmodule : wkt_top_tb
